// *** design/rsts_cfg.svh ***
`ifndef RSTS_CFG_SVH
`define RSTS_CFG_SVH
`define RSTS_CLK_HZ         100000000
`define RSTS_TEMP_PERIOD_S  10
`define RSTS_RAM_PERIOD_S   60
`define RSTS_ROM_PERIOD_S   10
`define RSTS_SET_PERIOD_S   10
`define RSTS_PULSE_S        5
`define RSTS_TEMP_WARN_LO   -16'sd40
`define RSTS_TEMP_WARN_HI   16'sd85
`define RSTS_TEMP_FAIL_LO   -16'sd50
`define RSTS_TEMP_FAIL_HI   16'sd100
`define RSTS_ADC_EXPECT     8'h10
`define RSTS_ST_TEMP_WARN   0
`define RSTS_ST_TEMP_FAIL   1
`define RSTS_ST_RAM         2
`define RSTS_ST_ROM         3
`define RSTS_ST_ADC         4
`define RSTS_ST_ACT_SET     5
`define RSTS_ST_NV_SET      6
`define RSTS_ST_DIFF_RAM    7
`define RSTS_ST_DIFF_ROM    8
`define RSTS_ST_DIFF_CFG    9
`define RSTS_ST_BOARD       10
`define RSTS_ST_W           11
`endif

// *** design/rsts_pkg.sv ***
package rsts_pkg;
  typedef struct packed {
    logic        valid;
    logic        pass;
  } rsts_result_t;

  typedef struct packed {
    logic        temp_valid;
    logic [15:0] temp_c;
    rsts_result_t ram;
    rsts_result_t rom;
    rsts_result_t act_set;
    rsts_result_t nv_set;
    rsts_result_t diff_ram;
    rsts_result_t diff_rom;
    rsts_result_t diff_cfg;
  } rsts_check_t;

  typedef struct packed {
    logic        temp;
    logic        ram;
    logic        rom;
    logic        act_set;
    logic        nv_set;
  } rsts_req_t;

  typedef enum logic [1:0] {
    RSTS_ALM_IDLE  = 2'b00,
    RSTS_ALM_PULSE = 2'b01,
    RSTS_ALM_LATCH = 2'b11
  } rsts_alm_t;
endpackage

// *** design/rsts_supervisor.sv ***
`include "rsts_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module rsts_supervisor #(
  parameter int unsigned SEC_CYCLES = `RSTS_CLK_HZ
) (
  input  wire logic                 i_ref_clk,          // System clock, 100 MHz.
  input  wire logic                 i_rst_n,            // Asynchronous reset, active low.
  input  wire logic                 i_ce,               // Clock enable.
  input  wire rsts_pkg::rsts_check_t i_chk,             // Check results from test engines.
  input  wire logic                 i_qcycle_tick,      // Quarter power-system cycle pulse.
  input  wire logic                 i_adc_conv,         // One A/D conversion done pulse.
  input  wire logic                 i_interval_tick,    // Processing interval end pulse.
  input  wire logic                 i_diff_hw_ack,      // Differential hardware answered.
  input  wire logic                 i_wdog_expired,     // Watchdog timer expired.
  input  wire logic                 i_crystal_ok,       // Crystal monitor sees oscillation.
  input  wire logic                 i_proc_fault,       // Processor fault pulse.
  input  wire logic [7:0]           i_proc_vector,      // Vector number of that fault.
  output var  rsts_pkg::rsts_req_t  o_req,              // Start pulses for periodic checks.
  output logic [`RSTS_ST_W-1:0]     o_status,           // Software-readable status report.
  output logic                      o_protection_en,    // Protection enabled.
  output logic                      o_contacts_en,      // Output contacts may energise.
  output logic                      o_diff_protection_enabled_flag, // Differential enabled.
  output logic                      o_diff_hw_alarm_flag, // Differential hardware alarm.
  output logic                      o_alarm,            // Alarm contact in alarm state.
  output logic                      o_proc_halt,        // Main processor halted.
  output logic                      o_crystal_fail_message, // Crystal_fail_message message shown.
  output logic                      o_processor_fault_message, // Vector message shown.
  output logic [7:0]                o_fault_vector      // Vector number for the message.
);
  import rsts_pkg::*;

  localparam int unsigned PULSE_CYC = `RSTS_PULSE_S * SEC_CYCLES;

  function automatic logic failed(input rsts_result_t r);
    failed = r.valid && !r.pass;
  endfunction

  // ==========================================================
  // Seconds tick and check schedule
  // ==========================================================
  logic [31:0] sec_cnt;
  logic        sec_tick;
  logic [5:0]  sec10;
  logic [5:0]  sec60;

  assign sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sec_cnt <= 32'h0;
      sec10   <= 6'h0;
      sec60   <= 6'h0;
    end
    else if (i_ce)
    begin
      sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      if (sec_tick)
      begin
        sec10 <= (sec10 == 6'(`RSTS_TEMP_PERIOD_S - 1)) ? 6'h0 : sec10 + 6'h1;
        sec60 <= (sec60 == 6'(`RSTS_RAM_PERIOD_S - 1)) ? 6'h0 : sec60 + 6'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_req <= '0;
    else if (i_ce)
    begin
      o_req.temp    <= sec_tick && sec10 == 6'(`RSTS_TEMP_PERIOD_S - 1);
      o_req.ram     <= sec_tick && sec60 == 6'(`RSTS_RAM_PERIOD_S - 1);
      o_req.rom     <= sec_tick && sec10 == 6'(`RSTS_ROM_PERIOD_S - 1);
      o_req.act_set <= sec_tick && sec10 == 6'(`RSTS_SET_PERIOD_S - 1);
      o_req.nv_set  <= sec_tick && sec10 == 6'(`RSTS_SET_PERIOD_S - 1);
    end
  end

  // ==========================================================
  // Conversion count per quarter cycle
  // ==========================================================
  logic [7:0] conv_cnt;
  logic       adc_bad;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      conv_cnt <= 8'h0;
      adc_bad  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_qcycle_tick)
      begin
        conv_cnt <= 8'h0;
        adc_bad  <= (conv_cnt + {7'h0, i_adc_conv}) != `RSTS_ADC_EXPECT;
      end
      else
      begin
        if (i_adc_conv && conv_cnt != 8'hff)
          conv_cnt <= conv_cnt + 8'h1;
        adc_bad <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Grading: latched failures and self-clearing warning
  // ==========================================================
  logic signed [15:0] t;
  logic               temp_warn_now;
  logic               temp_fail_now;
  logic               board_bad;

  assign t = $signed(i_chk.temp_c);
  assign temp_fail_now = i_chk.temp_valid &&
                         (t < `RSTS_TEMP_FAIL_LO || t > `RSTS_TEMP_FAIL_HI);
  assign temp_warn_now = (t < `RSTS_TEMP_WARN_LO || t > `RSTS_TEMP_WARN_HI);
  assign board_bad = i_interval_tick && (!i_diff_hw_ack || i_wdog_expired);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_status <= '0;
    else if (i_ce)
    begin
      if (i_chk.temp_valid)
        o_status[`RSTS_ST_TEMP_WARN] <= temp_warn_now;
      if (temp_fail_now)
        o_status[`RSTS_ST_TEMP_FAIL] <= 1'b1;
      if (failed(i_chk.ram))
        o_status[`RSTS_ST_RAM] <= 1'b1;
      if (failed(i_chk.rom))
        o_status[`RSTS_ST_ROM] <= 1'b1;
      if (adc_bad)
        o_status[`RSTS_ST_ADC] <= 1'b1;
      if (failed(i_chk.act_set))
        o_status[`RSTS_ST_ACT_SET] <= 1'b1;
      if (failed(i_chk.nv_set))
        o_status[`RSTS_ST_NV_SET] <= 1'b1;
      if (failed(i_chk.diff_ram))
        o_status[`RSTS_ST_DIFF_RAM] <= 1'b1;
      if (failed(i_chk.diff_rom))
        o_status[`RSTS_ST_DIFF_ROM] <= 1'b1;
      if (failed(i_chk.diff_cfg))
        o_status[`RSTS_ST_DIFF_CFG] <= 1'b1;
      if (board_bad)
        o_status[`RSTS_ST_BOARD] <= 1'b1;
    end
  end

  // ==========================================================
  // Dedicated crystal and processor supervision
  // ==========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_crystal_fail_message    <= 1'b0;
      o_processor_fault_message <= 1'b0;
      o_fault_vector            <= 8'h0;
    end
    else if (i_ce)
    begin
      if (!i_crystal_ok)
        o_crystal_fail_message <= 1'b1;
      if (i_proc_fault && !o_processor_fault_message)
      begin
        o_processor_fault_message <= 1'b1;
        o_fault_vector            <= i_proc_vector;
      end
    end
  end

  // Halt derives from the same causes, kept out of the status report.
  logic halt_now;
  assign halt_now = !i_crystal_ok || i_proc_fault;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_proc_halt <= 1'b0;
    else if (i_ce && halt_now)
      o_proc_halt <= 1'b1;
  end

  // ==========================================================
  // Protection actions
  // ==========================================================
  logic main_fail;
  logic diff_fail;
  logic next_main_fail;
  logic next_diff_fail;

  assign main_fail = |{o_status[`RSTS_ST_NV_SET:`RSTS_ST_TEMP_FAIL]} || o_proc_halt;
  assign diff_fail = |{o_status[`RSTS_ST_BOARD:`RSTS_ST_DIFF_RAM]};
  assign next_main_fail = temp_fail_now || failed(i_chk.ram) || failed(i_chk.rom) ||
                          adc_bad || failed(i_chk.act_set) || failed(i_chk.nv_set) ||
                          halt_now;
  assign next_diff_fail = failed(i_chk.diff_ram) || failed(i_chk.diff_rom) ||
                          failed(i_chk.diff_cfg) || board_bad;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_protection_en                <= 1'b1;
      o_contacts_en                  <= 1'b1;
      o_diff_protection_enabled_flag <= 1'b1;
      o_diff_hw_alarm_flag           <= 1'b0;
    end
    else if (i_ce)
    begin
      if (main_fail || next_main_fail)
      begin
        o_protection_en <= 1'b0;
        o_contacts_en   <= 1'b0;
      end
      if (diff_fail || next_diff_fail)
      begin
        o_diff_protection_enabled_flag <= 1'b0;
        o_diff_hw_alarm_flag           <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Alarm output: pulsed or latched
  // ==========================================================
  rsts_alm_t   alm;
  logic [31:0] pulse_cnt;
  logic        warn_rise;
  logic        warn_d;

  assign warn_rise = temp_warn_now && i_chk.temp_valid && !o_status[`RSTS_ST_TEMP_WARN];

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      alm       <= RSTS_ALM_IDLE;
      pulse_cnt <= 32'h0;
      o_alarm   <= 1'b0;
      warn_d    <= 1'b0;
    end
    else if (i_ce)
    begin
      warn_d <= warn_rise;
      unique case (alm)
        RSTS_ALM_IDLE, RSTS_ALM_PULSE:
        begin
          if (next_main_fail)
          begin
            alm     <= RSTS_ALM_LATCH;
            o_alarm <= 1'b1;
          end
          else if (next_diff_fail || warn_d)
          begin
            alm       <= RSTS_ALM_PULSE;
            pulse_cnt <= 32'(PULSE_CYC - 1);
            o_alarm   <= 1'b1;
          end
          else if (alm == RSTS_ALM_PULSE)
          begin
            if (pulse_cnt == 32'h0)
            begin
              alm     <= RSTS_ALM_IDLE;
              o_alarm <= 1'b0;
            end
            else
              pulse_cnt <= pulse_cnt - 32'h1;
          end
        end
        RSTS_ALM_LATCH:
          o_alarm <= 1'b1;
        default:
          alm <= RSTS_ALM_LATCH;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/rsts_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsts_props
  import rsts_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = 20
) (
  input wire logic                  i_ref_clk,        // System clock.
  input wire logic                  i_rst_n,          // Reset, active low.
  input wire logic                  i_ce,             // Clock enable.
  input wire rsts_pkg::rsts_check_t i_chk,            // Check results.
  input wire logic                  i_interval_tick,  // Interval end.
  input wire logic                  i_diff_hw_ack,    // Hardware answered.
  input wire logic                  i_wdog_expired,   // Watchdog expired.
  input wire logic                  i_crystal_ok,     // Crystal running.
  input wire rsts_pkg::rsts_req_t   o_req,            // Check starts.
  input wire logic [10:0]           o_status,         // Status report.
  input wire logic                  o_protection_en,  // Protection on.
  input wire logic                  o_contacts_en,    // Contacts allowed.
  input wire logic                  o_diff_protection_enabled_flag, // Differential on.
  input wire logic                  o_diff_hw_alarm_flag, // Differential alarm.
  input wire logic                  o_alarm,          // Alarm state.
  input wire logic                  o_proc_halt,      // Processor halted.
  input wire logic                  o_crystal_fail_message // Clock message.
);
  localparam int TP = 10 * SEC_CYCLES;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_RAM_FAIL: assert property (i_ce && i_chk.ram.valid && !i_chk.ram.pass |=>
    o_status[2] && !o_protection_en && o_alarm) else $error("ram failure not acted on");
  AST_DIFF_FAIL: assert property (i_ce && i_chk.diff_ram.valid && !i_chk.diff_ram.pass |=>
    !o_diff_protection_enabled_flag && o_diff_hw_alarm_flag && o_alarm)
    else $error("diff memory failure not acted on");
  AST_BOARD: assert property (i_ce && i_interval_tick && (!i_diff_hw_ack || i_wdog_expired)
    |=> o_status[10] && o_diff_hw_alarm_flag) else $error("board failure not acted on");
  AST_CRYSTAL: assert property (i_ce && !i_crystal_ok |=> o_crystal_fail_message &&
    o_proc_halt && !o_protection_en) else $error("crystal stop not acted on");
  AST_NO_REPORT: assert property ($rose(o_crystal_fail_message) |-> $stable(o_status))
    else $error("crystal stop entered in status");
  AST_CONTACTS: assert property (!o_protection_en |-> !o_contacts_en)
    else $error("contacts live while protection off");
  AST_HOLD: assert property (!o_protection_en |=> !o_protection_en[*8])
    else $error("protection disable not latched");
  AST_TEMP_FAIL: assert property (i_ce && i_chk.temp_valid && $signed(i_chk.temp_c) > 16'sd100
    |=> o_status[1] && !o_protection_en) else $error("temperature failure not acted on");
  AST_TEMP_PERIOD: assert property (i_ce && o_req.temp |-> ##TP o_req.temp)
    else $error("temperature sample period wrong");
endmodule
bind rsts_supervisor rsts_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.*);
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rsts_cfg.svh"
module tb;
  import rsts_pkg::*;
  localparam int SC = 20;
  logic        i_ref_clk, i_rst_n, i_ce, i_qcycle_tick, i_adc_conv, i_interval_tick;
  logic        i_diff_hw_ack, i_wdog_expired, i_crystal_ok, i_proc_fault;
  logic [7:0]  i_proc_vector, o_fault_vector;
  rsts_check_t i_chk;
  rsts_req_t   o_req;
  logic [10:0] o_status;
  logic        o_protection_en, o_contacts_en, o_diff_protection_enabled_flag;
  logic        o_diff_hw_alarm_flag, o_alarm, o_proc_halt;
  logic        o_crystal_fail_message, o_processor_fault_message;
  int          errors = 0;
  int          check_count = 0;
  rsts_supervisor #(.SEC_CYCLES(SC)) dut_u (.*);
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // ==========================================================
  // Shared helpers.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h", $time, m, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic do_rst();
    @(negedge i_ref_clk);
    {i_chk, i_qcycle_tick, i_adc_conv, i_interval_tick, i_wdog_expired} = '0;
    {i_proc_fault, i_proc_vector, i_rst_n} = '0;
    {i_ce, i_diff_hw_ack, i_crystal_ok} = 3'h7;
    step(4);
    i_rst_n = 1'b1;
  endtask
  function automatic rsts_check_t fail_of(input int k);
    rsts_check_t c = '0;
    case (k)
      0: c.ram.valid = 1'b1;
      1: c.rom.valid = 1'b1;
      2: c.act_set.valid = 1'b1;
      3: c.nv_set.valid = 1'b1;
      4: c.diff_ram.valid = 1'b1;
      5: c.diff_rom.valid = 1'b1;
      default: c.diff_cfg.valid = 1'b1;
    endcase
    return c;
  endfunction
  task automatic temp(input logic [15:0] v);
    i_chk.temp_valid = 1'b1;
    i_chk.temp_c = v;
    step(1);
    i_chk.temp_valid = 1'b0;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_fail();
    int bits[7] = '{2, 3, 5, 6, 7, 8, 9};
    for (int k = 0; k < 7; k++)
    begin
      do_rst();
      chk1(o_diff_protection_enabled_flag & o_protection_en & o_contacts_en, 1'b1, "reset");
      i_chk = fail_of(k);
      step(1);
      i_chk = '0;
      chkv(o_status, 16'h1 << bits[k], "status bit");
      chk1(o_protection_en, k > 3, "protection");
      chk1(o_diff_protection_enabled_flag, k < 4, "diff enable");
      chk1(o_diff_hw_alarm_flag, k > 3, "diff alarm");
      step(95);
      chk1(o_alarm, 1'b1, "alarm held");
      step(10);
      chk1(o_alarm, k < 4, "alarm pulsed or latched");
    end
    $display("test fail table done");
  endtask
  task automatic t_board();
    for (int j = 0; j < 2; j++)
    begin
      do_rst();
      {i_interval_tick, i_diff_hw_ack, i_wdog_expired} = {1'b1, j[0], j[0]};
      step(1);
      {i_interval_tick, i_diff_hw_ack, i_wdog_expired} = 3'h2;
      chkv(o_status, 16'h400, "board status");
      chk1(o_diff_protection_enabled_flag | ~o_protection_en, 1'b0, "board disable");
    end
    $display("test board done");
  endtask
  task automatic t_temp();
    do_rst();
    temp(16'd90);
    step(2);
    chkv(o_status, 16'h1, "warn hi");
    chk1(o_alarm & o_protection_en, 1'b1, "warn pulse");
    temp(16'd25);
    step(1);
    chkv(o_status, 16'h0, "warn clears");
    temp(-16'sd45);
    step(1);
    chkv(o_status, 16'h1, "warn lo");
    temp(16'd101);
    step(1);
    chkv(o_status, 16'h3, "fail band");
    chk1(o_protection_en, 1'b0, "fail disables");
    $display("test temperature done");
  endtask
  task automatic t_adc();
    do_rst();
    for (int q = 0; q < 4; q++)
    begin
      i_adc_conv = 1'b1;
      step((q % 2) ? 15 : 16);
      {i_adc_conv, i_qcycle_tick} = {q == 1, 1'b1};
      step(1);
      {i_adc_conv, i_qcycle_tick} = 2'h0;
      step(1);
      chk1(o_status[4], q == 3, "conversion count");
    end
    chk1(o_protection_en, 1'b0, "adc disables");
    $display("test adc done");
  endtask
  task automatic t_core();
    do_rst();
    i_crystal_ok = 1'b0;
    step(2);
    chk1(o_crystal_fail_message & o_proc_halt & o_alarm, 1'b1, "crystal");
    chkv({o_status, o_protection_en}, 16'h0, "crystal report");
    do_rst();
    {i_proc_fault, i_proc_vector} = 9'h15a;
    step(1);
    i_proc_vector = 8'h33;
    step(1);
    i_proc_fault = 1'b0;
    chkv(o_fault_vector, 16'h5a, "first vector");
    chk1(o_processor_fault_message & o_proc_halt & o_alarm, 1'b1, "proc fault");
    chkv({o_status, o_protection_en}, 16'h0, "proc report");
    $display("test core faults done");
  endtask
  task automatic t_period();
    int n = 0;
    do_rst();
    while (!o_req.temp && n < 400)
    begin
      step(1);
      n++;
    end
    chk1(n > 195 && n < 205, 1'b1, "first sample");
    chk1(o_req.rom & o_req.act_set & o_req.nv_set, 1'b1, "ten second checks");
    step(205);
    n = 0;
    while (!o_req.ram && n < 1300)
    begin
      step(1);
      n++;
    end
    chk1(n == 795, 1'b1, "memory test period");
    $display("test period done");
  endtask
  task automatic t_freeze();
    do_rst();
    {i_ce, i_crystal_ok} = 2'h0;
    i_chk = fail_of(0);
    step(2);
    chkv({o_status, o_protection_en, o_proc_halt}, 16'h2, "frozen");
    {i_ce, i_crystal_ok} = 2'h3;
    step(1);
    i_chk = '0;
    chkv({o_status, o_protection_en}, 16'h8, "thawed");
    $display("test clock enable done");
  endtask
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    errors++;
    wrap_up();
  end
  initial
  begin
    i_rst_n = 1'b0;
    t_fail();
    t_board();
    t_temp();
    t_adc();
    t_core();
    t_period();
    t_freeze();
    wrap_up();
  end
endmodule
`default_nettype wire
